// file: src/acl_loader.sv
// Purpose: learns host bit rate from 01h byte and loads calibration words from memory
// Assumes: memory returns data one cycle after address; temperature pointer is synchronous
// Notes:   the learned count is held in 8 bits; one bit period of the oscillator
//
// Operation
// - first byte after reset or reinit is learning
// - learning byte must equal 01h
// - start edge begins synchronization; data LSB first
// - bit time counted in oscillator periods
// - count kept in 8-bit register for receive
// - lock byte and override set pin first
// - offset word at 000h plus twice pointer
// - span word at 200h or 1A0h region
// - fixed words read from fixed pair addresses
// - five calibration registers are kept
// - frame: start, eight data, stop, idle high
// - rate usable from 4800 to 38400; here the 8-bit count at 125 MHz caps one bit at 255 cycles
// - FFh byte returns receiver to power-up state
// - pointer updated every 1ms, trims refreshed
`timescale 1ns/1ps
module acl_loader #(
    parameter int POR_CYC     = acl_pkg::POR_WAIT_CYC,
    parameter int REFRESH_CYC = acl_pkg::REFRESH_CYC
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_serial_line,
    input  wire logic        i_lock_override,
    input  wire logic [7:0]  i_temp_code,
    input  wire logic [7:0]  i_mem_data,
    output logic      [9:0]  o_mem_addr,
    output logic             o_mem_rd,
    output logic             o_serial_enabled,
    output logic             o_rate_learned,
    output logic      [7:0]  o_bit_period_count,
    output logic      [7:0]  o_rx_byte,
    output logic             o_rx_valid,
    output logic      [7:0]  o_temp_pointer,
    output logic      [15:0] o_setup_word,
    output logic      [15:0] o_offset_trim_word,
    output logic      [15:0] o_offset_tempco_word,
    output logic      [15:0] o_span_trim_word,
    output logic      [15:0] o_span_tempco_word,
    output logic             o_load_done
);

    // loader: power-on wait, then fixed and indexed word fetches
    typedef enum logic [3:0] {
        LD_WAIT = 4'b0001,
        LD_ADDR = 4'b0010,
        LD_DATA = 4'b0100,
        LD_IDLE = 4'b1000
    } acl_ld_e;

    acl_ld_e      ld_state;
    logic [2:0]   word_idx;   // 0 lock,1 setup,2 otc,3 stc,4 offs,5 span
    logic         byte_hi;
    logic [7:0]   low_byte;
    logic [31:0]  ld_timer;
    logic         first_pass;
    logic [7:0]   lock_byte_value;
    logic         ov_sync;    // synchronised override pin

    // pointer clamp and table addresses
    wire  [7:0]   ptr_clamped = (o_temp_pointer >= acl_pkg::PTR_LAST) ?
                                acl_pkg::PTR_LAST : o_temp_pointer;
    wire  [9:0]   ptr_x2      = {1'b0, ptr_clamped, 1'b0};
    wire  [9:0]   offs_addr   = acl_pkg::OFFS_BASE + ptr_x2;
    wire  [9:0]   span_addr   = (ptr_clamped < acl_pkg::PTR_SPLIT) ?
                                acl_pkg::SPAN_BASE_LO + ptr_x2 :
                                acl_pkg::SPAN_BASE_HI +
                                {1'b0, ptr_clamped - acl_pkg::PTR_SPLIT, 1'b0};

    // word address for each load step
    function automatic logic [9:0] word_addr(input logic [2:0] idx,
                                              input logic [9:0] oa,
                                              input logic [9:0] sa);
        case (idx)
            3'd0:    word_addr = acl_pkg::LOCK_ADDR;
            3'd1:    word_addr = acl_pkg::SETUP_ADDR;
            3'd2:    word_addr = acl_pkg::OTC_ADDR;
            3'd3:    word_addr = acl_pkg::STC_ADDR;
            3'd4:    word_addr = oa;
            default: word_addr = sa;
        endcase
    endfunction : word_addr

    wire  [9:0]   cur_addr    = word_addr(word_idx, offs_addr, span_addr) +
                                {9'd0, byte_hi};
    wire  [15:0]  got_word    = {i_mem_data, low_byte};
    wire          timer_done  = (ld_timer == 32'd0);
    // serial allowed when lock clear or override held
    wire          unlocked    = (lock_byte_value != acl_pkg::LOCK_SET) | ov_sync;

    // loader sequence: power-on wait, lock, then fixed words and trims every period
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ld_state   <= LD_WAIT;
            ld_timer   <= 32'd0;
            word_idx   <= 3'd0;
            byte_hi    <= 1'b0;
            low_byte   <= 8'h00;
            first_pass <= 1'b1;
            o_mem_addr <= 10'h000;
            o_mem_rd   <= 1'b0;
            o_load_done <= 1'b0;
            o_temp_pointer       <= 8'h00;
            lock_byte_value      <= 8'h00;
            o_setup_word         <= acl_pkg::WORD_RST;
            o_offset_trim_word   <= acl_pkg::WORD_RST;
            o_offset_tempco_word <= acl_pkg::WORD_RST;
            o_span_trim_word     <= acl_pkg::WORD_RST;
            o_span_tempco_word   <= acl_pkg::WORD_RST;
        end else begin
            o_mem_rd <= 1'b0;
            case (ld_state)
                LD_WAIT: begin
                    if (first_pass && ld_timer != POR_CYC[31:0]) begin
                        ld_timer <= ld_timer + 32'd1;
                    end else begin
                        ld_state       <= LD_ADDR;
                        o_temp_pointer <= i_temp_code;
                    end
                end
                LD_ADDR: begin
                    o_mem_addr <= cur_addr;
                    o_mem_rd   <= 1'b1;
                    ld_state   <= LD_DATA;
                end
                LD_DATA: begin
                    if (!o_mem_rd) begin
                        if (!byte_hi) begin
                            low_byte <= i_mem_data;
                            byte_hi  <= 1'b1;
                            ld_state <= LD_ADDR;
                        end else begin
                            byte_hi <= 1'b0;
                            case (word_idx)
                                3'd0:    lock_byte_value      <= low_byte;
                                3'd1:    o_setup_word         <= got_word;
                                3'd2:    o_offset_tempco_word <= got_word;
                                3'd3:    o_span_tempco_word   <= got_word;
                                3'd4:    o_offset_trim_word   <= got_word;
                                default: o_span_trim_word     <= got_word;
                            endcase
                            if (word_idx == 3'd5) begin
                                word_idx    <= 3'd1;
                                ld_state    <= LD_IDLE;
                                first_pass  <= 1'b0;
                                o_load_done <= 1'b1;
                                ld_timer    <= REFRESH_CYC[31:0] - 32'd1;
                            end else begin
                                word_idx <= word_idx + 3'd1;
                                ld_state <= LD_ADDR;
                            end
                        end
                    end
                end
                LD_IDLE: begin
                    if (timer_done) begin
                        ld_state <= LD_WAIT;
                    end else begin
                        ld_timer <= ld_timer - 32'd1;
                    end
                end
                default: ld_state <= LD_WAIT;
            endcase
        end
    end

    // serial receive: learning, framing and byte delivery
    typedef enum logic [4:0] {
        RX_OFF   = 5'b00001,
        RX_IDLE  = 5'b00010,
        RX_START = 5'b00100,
        RX_DATA  = 5'b01000,
        RX_STOP  = 5'b10000
    } acl_rx_e;

    // two-stage synchronisers for pins
    logic [1:0]   line_sync;
    logic [1:0]   ov_pipe;
    logic         line_prev;
    wire          line = line_sync[1];

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            line_sync <= 2'b11;
            ov_pipe   <= 2'b00;
            line_prev <= 1'b1;
        end else begin
            line_sync <= {line_sync[0], i_serial_line};
            ov_pipe   <= {ov_pipe[0], i_lock_override};
            line_prev <= line;
        end
    end
    assign ov_sync = ov_pipe[1];

    acl_rx_e      rx_state;
    logic [7:0]   bit_timer;
    logic [2:0]   bit_idx;
    logic [7:0]   shreg;
    logic [7:0]   learn_cnt;
    logic [1:0]   learn_phase;   // 0 wait start, 1 timing start bit
    wire          fall_edge  = line_prev & ~line;
    wire          rise_edge  = ~line_prev & line;
    wire          bit_tick   = (bit_timer == 8'd0);
    wire  [7:0]   half_count = {1'b0, o_bit_period_count[7:1]};
    wire  [7:0]   next_byte  = {line, shreg[7:1]};

    // learning times the start bit alone: bit0 of the learning byte is high,
    // so its rising edge closes exactly one bit period
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_state           <= RX_OFF;
            bit_timer          <= 8'd0;
            bit_idx            <= 3'd0;
            shreg              <= 8'h00;
            learn_cnt          <= 8'd0;
            learn_phase        <= 2'd0;
            o_bit_period_count <= acl_pkg::BIT_CNT_RST;
            o_rate_learned     <= 1'b0;
            o_rx_byte          <= 8'h00;
            o_rx_valid         <= 1'b0;
            o_serial_enabled   <= 1'b0;
        end else begin
            o_rx_valid       <= 1'b0;
            o_serial_enabled <= o_load_done & unlocked;
            case (rx_state)
                RX_OFF: begin
                    if (o_load_done && unlocked) begin
                        rx_state <= RX_IDLE;
                    end
                end
                RX_IDLE: begin
                    if (!unlocked) begin
                        rx_state <= RX_OFF;
                    end else if (fall_edge) begin
                        learn_cnt <= 8'd1;
                        bit_timer <= half_count;
                        bit_idx   <= 3'd0;
                        rx_state  <= o_rate_learned ? RX_START : RX_DATA;
                        learn_phase <= {1'b0, ~o_rate_learned};
                    end
                end
                RX_START: begin
                    if (bit_tick) begin
                        bit_timer <= o_bit_period_count - 8'd1; // tick every count cycles
                        rx_state  <= line ? RX_IDLE : RX_DATA;
                    end else begin
                        bit_timer <= bit_timer - 8'd1;
                    end
                end
                RX_DATA: begin
                    if (learn_phase == 2'd1) begin
                        // count oscillator periods across the start bit
                        if (rise_edge) begin
                            o_bit_period_count <= learn_cnt;
                            learn_phase <= 2'd2;
                            bit_idx     <= 3'd0; // bit0 sampled at its middle
                            shreg       <= 8'h00;
                            bit_timer   <= {1'b0, learn_cnt[7:1]};
                        end else if (learn_cnt != 8'hFF) begin
                            learn_cnt <= learn_cnt + 8'd1;
                        end
                    end else if (bit_tick) begin
                        shreg     <= next_byte;
                        bit_timer <= o_bit_period_count - 8'd1;
                        bit_idx   <= bit_idx + 3'd1;
                        if (bit_idx == 3'd7) begin
                            rx_state <= RX_STOP;
                        end
                    end else begin
                        bit_timer <= bit_timer - 8'd1;
                    end
                end
                RX_STOP: begin
                    if (bit_tick) begin
                        rx_state    <= RX_IDLE;
                        learn_phase <= 2'd0;
                        if (line) begin
                            if (!o_rate_learned) begin
                                o_rate_learned <= (shreg == acl_pkg::LEARN_BYTE);
                            end else if (shreg == acl_pkg::REINIT_BYTE) begin
                                o_rate_learned <= 1'b0;
                            end else begin
                                o_rx_byte  <= shreg;
                                o_rx_valid <= 1'b1;
                            end
                        end
                    end else begin
                        bit_timer <= bit_timer - 8'd1;
                    end
                end
                default: rx_state <= RX_OFF;
            endcase
        end
    end

endmodule : acl_loader

// file: src/acl_pkg.sv
// Purpose: constants for the autobaud and calibration table loader
// Assumes: 125 MHz system clock, byte-wide nonvolatile memory with a one-cycle read
// Notes:   addresses are byte addresses into a 768-byte array
package acl_pkg;
    localparam int          CLK_MHZ         = 125;
    localparam int          POR_WAIT_US     = 1000;
    localparam int          POR_WAIT_CYC    = POR_WAIT_US * CLK_MHZ;
    localparam int          REFRESH_US      = 1000;
    localparam int          REFRESH_CYC     = REFRESH_US * CLK_MHZ;
    localparam logic [7:0]  LEARN_BYTE      = 8'h01;
    localparam logic [7:0]  REINIT_BYTE     = 8'hFF;
    localparam logic [7:0]  LOCK_SET        = 8'hFF;
    localparam logic [9:0]  OFFS_BASE       = 10'h000;
    localparam logic [9:0]  SPAN_BASE_LO    = 10'h200;
    localparam logic [9:0]  SPAN_BASE_HI    = 10'h1A0;
    localparam logic [7:0]  PTR_SPLIT       = 8'h80;
    localparam logic [7:0]  PTR_LAST        = 8'hAF;
    localparam logic [9:0]  SETUP_ADDR      = 10'h160;
    localparam logic [9:0]  OTC_ADDR        = 10'h164;
    localparam logic [9:0]  STC_ADDR        = 10'h168;
    localparam logic [9:0]  LOCK_ADDR       = 10'h16A;
    localparam int          ADDR_W          = 10;
    localparam int          NUM_WORDS       = 5;
    localparam logic [7:0]  BIT_CNT_RST     = 8'h00;
    localparam logic [15:0] WORD_RST        = 16'h0000;
endpackage : acl_pkg

// file: dv/acl_loader_sva.sv
// Purpose: port checker for the autobaud and calibration loader
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to the loader from the testbench top
`timescale 1ns/1ps
module acl_loader_sva #(
    parameter int POR_CYC     = 50,
    parameter int REFRESH_CYC = 200
) (
    input wire logic       i_sys_clk,
    input wire logic       i_rst_b,
    input wire logic [9:0] o_mem_addr,
    input wire logic       o_mem_rd,
    input wire logic       o_serial_enabled,
    input wire logic       o_rate_learned,
    input wire logic [7:0] o_bit_period_count,
    input wire logic [7:0] o_rx_byte,
    input wire logic       o_rx_valid,
    input wire logic [7:0] o_temp_pointer,
    input wire logic       o_load_done
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    int         por_cnt;
    logic [7:0] clamp;
    logic [9:0] span_addr;
    // cycles since reset release, saturating
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            por_cnt <= 0;
        end else if (por_cnt < POR_CYC) begin
            por_cnt <= por_cnt + 1;
        end
    end
    // expected table entry for the latched pointer
    assign clamp     = (o_temp_pointer >= 8'hAF) ? 8'hAF : o_temp_pointer;
    assign span_addr = (clamp < 8'h80) ? {1'b0, clamp, 1'b0} + 10'h200
                                       : {1'b0, clamp - 8'h80, 1'b0} + 10'h1A0;
    rd_spacing_a: assert property (o_mem_rd |=> !o_mem_rd ##1 !o_mem_rd)
        else $error("memory reads closer than three cycles");
    byte_pair_a: assert property (o_mem_rd && !o_mem_addr[0] |->
        ##3 o_mem_rd && o_mem_addr == $past(o_mem_addr, 3) + 10'h1)
        else $error("high byte not read after low byte");
    offset_addr_a: assert property (o_mem_rd && o_mem_addr < 10'h160 |->
        o_mem_addr[9:1] == {1'b0, clamp}) else $error("offset table address wrong");
    span_addr_a: assert property (o_mem_rd && o_mem_addr >= 10'h1A0 |->
        o_mem_addr[9:1] == span_addr[9:1]) else $error("span table address wrong");
    por_wait_a: assert property (o_mem_rd |-> por_cnt >= POR_CYC - 2)
        else $error("memory read before power-on wait");
    enable_load_a: assert property (o_serial_enabled |-> o_load_done)
        else $error("serial enabled before load");
    learn_gate_a: assert property ($rose(o_rate_learned) |-> o_serial_enabled)
        else $error("rate learned while serial disabled");
    rx_learned_a: assert property (o_rx_valid |-> o_rate_learned)
        else $error("byte delivered before rate learned");
    reinit_hidden_a: assert property (o_rx_valid |-> o_rx_byte != 8'hFF)
        else $error("reinit byte delivered as data");
    rx_pulse_a: assert property (o_rx_valid |=> !o_rx_valid)
        else $error("receive strobe longer than one cycle");
    period_hold_a: assert property (o_rate_learned && $past(o_rate_learned) |->
        $stable(o_bit_period_count)) else $error("bit period changed while learned");
    done_sticky_a: assert property (o_load_done |=> o_load_done)
        else $error("load done dropped");
endmodule : acl_loader_sva

// file: dv/acl_mem_model.sv
// Purpose: byte-wide nonvolatile memory behind the loader
// Assumes: data is returned the cycle after a read strobe
// Notes:   each byte is its address folded to eight bits; i_lock sets the lock byte
`timescale 1ns/1ps
module acl_mem_model (
    input  wire logic       i_sys_clk,
    input  wire logic [9:0] i_addr,
    input  wire logic       i_rd,
    input  wire logic       i_lock,
    output logic      [7:0] o_data
);
    // answer a read, otherwise keep the bus moving
    always_ff @(posedge i_sys_clk) begin
        if (i_rd && i_lock && i_addr == 10'h16A) begin
            o_data <= 8'hFF;
        end else if (i_rd) begin
            o_data <= i_addr[7:0] ^ {6'h0, i_addr[9:8]};
        end else begin
            o_data <= ~o_data;
        end
    end
endmodule : acl_mem_model

// file: dv/tb_acl_loader.sv
// Purpose: self-checking bench for the loader
// Assumes: shortened power-on and refresh counts
// Notes:   host frames driven by tasks, memory by a model
`timescale 1ns/1ps
module tb_acl_loader;
    logic        i_sys_clk = 1'b0, i_rst_b = 1'b0, i_serial_line = 1'b1;
    logic        i_lock_override = 1'b0, lock_set = 1'b0;
    logic [7:0]  i_temp_code = 8'h10, i_mem_data, o_bit_period_count, o_rx_byte, o_temp_pointer;
    logic [9:0]  o_mem_addr;
    logic        o_mem_rd, o_serial_enabled, o_rate_learned, o_rx_valid, o_load_done;
    logic [15:0] o_setup_word, o_offset_trim_word, o_offset_tempco_word;
    logic [15:0] o_span_trim_word, o_span_tempco_word;
    int          mismatches = 0, checked = 0, cycles = 0, rx_count = 0;
    logic [7:0]  rx_last;
    acl_loader #(.POR_CYC(50), .REFRESH_CYC(200)) acl_loader_inst (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_serial_line(i_serial_line),
        .i_lock_override(i_lock_override), .i_temp_code(i_temp_code), .i_mem_data(i_mem_data),
        .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_serial_enabled(o_serial_enabled),
        .o_rate_learned(o_rate_learned), .o_bit_period_count(o_bit_period_count),
        .o_rx_byte(o_rx_byte), .o_rx_valid(o_rx_valid), .o_temp_pointer(o_temp_pointer),
        .o_setup_word(o_setup_word), .o_offset_trim_word(o_offset_trim_word),
        .o_offset_tempco_word(o_offset_tempco_word), .o_span_trim_word(o_span_trim_word),
        .o_span_tempco_word(o_span_tempco_word), .o_load_done(o_load_done));
    acl_mem_model acl_mem_model_inst (.i_sys_clk(i_sys_clk), .i_addr(o_mem_addr),
        .i_rd(o_mem_rd), .i_lock(lock_set), .o_data(i_mem_data));
    // clock, hang guard and receive monitor
    always #4 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cycles++;
        if (o_rx_valid === 1'b1) begin
            rx_count++;
            rx_last = o_rx_byte;
        end
        if (cycles == 20000) begin
            mismatches++;
            $display("Error at %0t: timeout", $time);
            final_report();
        end
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp
    function automatic logic [15:0] word(input logic [9:0] a);
        logic [9:0] h;
        h = a + 10'h1;
        return {h[7:0] ^ {6'h0, h[9:8]}, a[7:0] ^ {6'h0, a[9:8]}};
    endfunction : word
    task automatic send(input logic [7:0] b, input int per, input logic stop);
        logic [9:0] fr;
        fr = {stop, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            i_serial_line <= (i < 10) ? fr[i] : 1'b1;
            repeat (per) @(posedge i_sys_clk);
        end
    endtask : send
    task automatic wait_done;
        for (int i = 0; i < 2000 && o_load_done !== 1'b1; i++) @(posedge i_sys_clk);
        @(posedge i_sys_clk);
        cmp(o_load_done, 1'b1, "load done");
    endtask : wait_done
    task automatic test_load;
        wait_done();
        cmp(o_setup_word, word(10'h160), "setup word");
        cmp(o_offset_tempco_word, word(10'h164), "offset tempco");
        cmp(o_span_tempco_word, word(10'h168), "span tempco");
        cmp(o_offset_trim_word, word(10'h020), "offset trim");
        cmp(o_span_trim_word, word(10'h220), "span trim");
        cmp(o_serial_enabled, 1'b1, "serial enabled");
        $display("test load done");
    endtask : test_load
    task automatic test_refresh;
        logic [7:0] t[3]  = '{8'h90, 8'hC0, 8'h7F};
        logic [9:0] oa[3] = '{10'h120, 10'h15E, 10'h0FE};
        logic [9:0] sa[3] = '{10'h1C0, 10'h1FE, 10'h2FE};
        for (int k = 0; k < 3; k++) begin
            i_temp_code <= t[k];
            repeat (460) @(posedge i_sys_clk);
            cmp(o_offset_trim_word, word(oa[k]), "offset trim");
            cmp(o_span_trim_word, word(sa[k]), "span trim");
        end
        $display("test refresh done");
    endtask : test_refresh
    task automatic test_learn_rx;
        cmp(o_serial_enabled, 1'b1, "enabled before learn");
        cmp(o_rate_learned, 1'b0, "learned early");
        send(8'h01, 40, 1'b1);
        cmp(o_rate_learned, 1'b1, "learned");
        cmp(o_bit_period_count inside {[39:41]}, 1'b1, "period");
        cmp(rx_count, 0, "learn byte delivered");
        send(8'hA5, 40, 1'b1);
        cmp(rx_last, 8'hA5, "rx byte");
        send(8'h5A, 40, 1'b1);
        cmp(rx_last, 8'h5A, "rx byte");
        send(8'h3C, 40, 1'b0);
        cmp(rx_count, 2, "bad stop accepted");
        $display("test learn and receive done");
    endtask : test_learn_rx
    task automatic test_reinit;
        send(8'hFF, 40, 1'b1);
        cmp(o_rate_learned, 1'b0, "reinit");
        send(8'h77, 40, 1'b1);
        cmp(o_rate_learned, 1'b0, "wrong learn byte");
        send(8'h01, 20, 1'b1);
        cmp(o_bit_period_count inside {[19:21]}, 1'b1, "relearned period");
        send(8'hC3, 20, 1'b1);
        cmp(rx_last, 8'hC3, "rx at new rate");
        cmp(rx_count, 3, "rx count");
        $display("test reinit done");
    endtask : test_reinit
    task automatic test_reset;
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        cmp(o_load_done, 1'b0, "load done in reset");
        cmp(o_rate_learned, 1'b0, "learned in reset");
        i_rst_b <= 1'b1;
        wait_done();
        cmp(o_setup_word, word(10'h160), "setup after reset");
        $display("test reset done");
    endtask : test_reset
    task automatic test_lock;
        lock_set <= 1'b1;
        i_rst_b  <= 1'b0;
        @(posedge i_sys_clk);
        i_rst_b  <= 1'b1;
        wait_done();
        cmp(o_serial_enabled, 1'b0, "enabled while locked");
        send(8'h01, 40, 1'b1);
        cmp(o_rate_learned, 1'b0, "learned while locked");
        i_lock_override <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        cmp(o_serial_enabled, 1'b1, "override enables");
        send(8'h01, 40, 1'b1);
        cmp(o_rate_learned, 1'b1, "learned with override");
        $display("test lock done");
    endtask : test_lock
    task automatic final_report;
        $display("Counts: %0d checks, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // main sequence
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        test_load();
        test_learn_rx();
        test_reinit();
        test_refresh();
        test_reset();
        test_lock();
        final_report();
    end
endmodule : tb_acl_loader
bind acl_loader acl_loader_sva #(.POR_CYC(POR_CYC), .REFRESH_CYC(REFRESH_CYC)) acl_loader_sva_inst (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
    .o_serial_enabled(o_serial_enabled), .o_rate_learned(o_rate_learned),
    .o_bit_period_count(o_bit_period_count), .o_rx_byte(o_rx_byte), .o_rx_valid(o_rx_valid),
    .o_temp_pointer(o_temp_pointer), .o_load_done(o_load_done));
